/* File: tcs_pkg.sv */
`default_nettype none
package tcs_pkg;
	// Link framing
	localparam int          CLK_PERIOD_NS  = 50;
	localparam int          IDLE_GAP_NS    = 2000000;
	localparam int          IDLE_GAP_CYC   = (IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  MSG_MIN        = 4'h3;
	localparam logic [3:0]  MSG_MAX        = 4'he;
	localparam logic [3:0]  RESP_HDR_LEN   = 4'h4;
	localparam logic [7:0]  ADDR_DEFAULT   = 8'hfe;
	localparam logic [7:0]  ADDR_GLOBAL    = 8'hff;
	localparam logic [7:0]  CMD_RESET_CODE = 8'h01;
	localparam logic [7:0]  CMD_START_CODE = 8'h02;

	// Transfer error word, high byte in [15:8]
	localparam int SCI_CHAR     = 0;
	localparam int SCI_PARAM    = 1;
	localparam int SCI_CSUM     = 2;
	localparam int SCI_MOTION   = 3;
	localparam int SCI_COUNT    = 4;
	localparam int SCI_DEVERR   = 6;
	localparam int SCI_NOTREADY = 7;
	localparam int SCI_DIR      = 8;
	localparam int SCI_CMD      = 9;

	// Device error word, high byte in [15:8]
	localparam int DEV_UNDERV   = 1;
	localparam int DEV_POSWIN   = 2;
	localparam int DEV_TEMP     = 3;
	localparam int DEV_BLK_CCW  = 4;
	localparam int DEV_BLK_CW   = 5;
	localparam int DEV_LIM_CCW  = 8;
	localparam int DEV_LIM_CW   = 9;
	localparam int DEV_MEM      = 12;
	localparam int DEV_POSREC   = 14;
	localparam int DEV_TIMEOUT  = 15;
	localparam logic [15:0] DEV_STOP_MASK  = 16'h0338;

	// Register map
	localparam logic [3:0]  REG_OWN_ADDR   = 4'h0;
	localparam logic [3:0]  REG_DEV_ERR    = 4'h4;
	localparam logic [3:0]  REG_SCI_ERR    = 4'h8;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {TCS_RX, TCS_EVAL, TCS_CORE, TCS_TX} tcs_state_e;
endpackage : tcs_pkg
`default_nettype wire

/* File: tcs_check.sv */
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: checksum is XOR of all preceding message bytes, one byte.
// RULE2: sender computes checksum and appends it as the final byte.
// RULE3: receiver XORs all but the last byte and compares to it.
// RULE4: every response carries a two-byte transfer error word, zero when clean.
// RULE5: low transfer error bit 0 flags framing, parity or overrun fault.
// RULE6: low transfer error bit 1 flags an out-of-range parameter.
// RULE7: low bit 2 flags checksum mismatch, bit 4 wrong character count.
// RULE8: low bit 3 flags unsuitable motion status or internal error.
// RULE9: low bit 6 set whenever any device error bit is set.
// RULE10: low bit 7 flags a start command while drive is not ready.
// RULE11: high bit 0 wrong direction after blocking, bit 1 unknown command.
// RULE12: device error bits stay latched until a reset command.
// RULE13: device error low bit 1 flags undervoltage.
// RULE14: device error low bit 2 flags position outside positioning window.
// RULE15: device error low bit 3 flags overtemperature; drive stops.
// RULE16: CCW blocking sets low bit 4, stops, allows only CW.
// RULE17: CW blocking sets low bit 5, stops, allows only CCW.
// RULE18: CCW range limit sets high bit 0, stops, CW still allowed.
// RULE19: CW range limit sets high bit 1, stops, CCW still allowed.
// RULE20: high bit 4 flags memory fault, bit 6 position recording fault.
// RULE21: high bit 7 flags communication timeout.
// RULE22: status words go high byte first; reserved bits read zero.
// RULE23: telegram ends after the idle gap with no new byte.
// RULE24: response is address, echoed command, transfer error word, parameters, checksum.
module tcs_check #(
	parameter int GAP_CYC = tcs_pkg::IDLE_GAP_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_fault,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	output logic             cmd_valid,
	output logic [7:0]       cmd_code,
	output logic [3:0]       cmd_len,
	input  wire logic [2:0]  cmd_param_sel,
	output logic [7:0]       cmd_param_byte,
	input  wire logic        core_done,
	input  wire logic        core_param_bad,
	input  wire logic        core_motion_bad,
	input  wire logic        core_unknown,
	input  wire logic        core_dir_cw,
	input  wire logic        core_dir_ccw,
	input  wire logic [3:0]  core_resp_len,
	output logic [3:0]       resp_idx,
	input  wire logic [7:0]  resp_byte,
	input  wire logic        drive_ready,
	input  wire logic        fault_undervolt,
	input  wire logic        fault_poswin,
	input  wire logic        fault_overtemp,
	input  wire logic        fault_block_ccw,
	input  wire logic        fault_block_cw,
	input  wire logic        fault_limit_ccw,
	input  wire logic        fault_limit_cw,
	input  wire logic        fault_memory,
	input  wire logic        fault_posrec,
	input  wire logic        fault_comm_timeout,
	output logic             drive_stop,
	output logic             allow_cw,
	output logic             allow_ccw,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import tcs_pkg::*;

	tcs_state_e  state;
	logic [7:0]  rx_buf [0:13];
	logic [3:0]  rx_cnt;
	logic [7:0]  run_xor;
	logic [7:0]  prev_xor;
	logic [7:0]  last_byte;
	logic        char_fault;
	logic [31:0] gap_cnt;
	logic [15:0] sci_err;
	logic [15:0] dev_err;
	logic [15:0] fault_vec;
	logic        clr_dev;
	logic        reply;
	logic [7:0]  own_addr;
	logic [3:0]  tx_idx;
	logic [3:0]  tx_last;
	logic [7:0]  tx_csum;
	logic [7:0]  sel_byte;
	logic [15:0] sci_word;
	logic        len_ok;
	logic        tel_ok;
	logic        tx_fire;
	logic        eval_busy;
	logic        rx_restart;

	assign len_ok    = (rx_cnt >= MSG_MIN) && (rx_cnt <= MSG_MAX);
	assign tel_ok    = len_ok && !char_fault && (prev_xor == last_byte);
	assign tx_fire   = tx_valid && tx_ready;
	assign eval_busy = (tel_ok && (rx_buf[0] == own_addr || rx_buf[0] == ADDR_GLOBAL))
		|| ((rx_cnt >= 4'h2) && (rx_buf[0] == own_addr));
	// A global telegram has no reply, so its buffer is freed as soon as the core is done
	assign rx_restart = (state == TCS_TX && tx_fire && tx_idx == tx_last)
		|| (state == TCS_CORE && core_done && !reply) || (state == TCS_EVAL && !eval_busy);
	assign cmd_code  = rx_buf[1];
	assign cmd_len   = rx_cnt;
	assign cmd_param_byte = rx_buf[4'(cmd_param_sel) + 4'h2];
	assign resp_idx  = tx_idx - RESP_HDR_LEN;
	// Device error summary always live, so a fault latched mid-telegram is still reported
	assign sci_word  = sci_err | (16'(|dev_err) << SCI_DEVERR); // RULE9
	assign drive_stop = |(dev_err & DEV_STOP_MASK); // RULE15
	assign allow_cw  = !(dev_err[DEV_BLK_CW] || dev_err[DEV_LIM_CW]); // RULE17 RULE19
	assign allow_ccw = !(dev_err[DEV_BLK_CCW] || dev_err[DEV_LIM_CCW]); // RULE16 RULE18

	// Receive: bytes are ignored while answering, the line is half duplex
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_cnt     <= 4'h0;
			run_xor    <= 8'h00;
			prev_xor   <= 8'h00;
			last_byte  <= 8'h00;
			char_fault <= 1'b0;
			gap_cnt    <= 32'h0;
		end else if (state == TCS_RX) begin
			if (rx_valid) begin
				if (rx_cnt <= MSG_MAX) begin
					rx_cnt <= rx_cnt + 4'h1;
				end
				prev_xor   <= run_xor; // RULE3
				run_xor    <= run_xor ^ rx_data; // RULE1
				last_byte  <= rx_data;
				char_fault <= char_fault | rx_fault; // RULE5
				gap_cnt    <= 32'h0;
			end else if (rx_cnt != 4'h0) begin
				gap_cnt <= gap_cnt + 32'h1; // RULE23
			end
		end else if (rx_restart) begin
			rx_cnt     <= 4'h0;
			run_xor    <= 8'h00;
			prev_xor   <= 8'h00;
			char_fault <= 1'b0;
			gap_cnt    <= 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (state == TCS_RX && rx_valid && rx_cnt < MSG_MAX) begin
			rx_buf[rx_cnt] <= rx_data;
		end
	end

	// Sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state     <= TCS_RX;
			sci_err   <= 16'h0000;
			cmd_valid <= 1'b0;
			reply     <= 1'b0;
			clr_dev   <= 1'b0;
			tx_last   <= 4'h0;
		end else begin
			cmd_valid <= 1'b0;
			clr_dev   <= 1'b0;
			unique case (state)
				TCS_RX: begin
					if (rx_cnt != 4'h0 && !rx_valid && gap_cnt >= 32'(GAP_CYC - 1)) begin
						state <= TCS_EVAL; // RULE23
					end
				end
				TCS_EVAL: begin
					// Global telegrams act on the drive but are never answered
					reply   <= (rx_cnt >= 4'h2) && (rx_buf[0] == own_addr);
					sci_err <= 16'h0000;
					sci_err[SCI_CHAR]  <= char_fault; // RULE5
					sci_err[SCI_COUNT] <= !len_ok; // RULE7
					sci_err[SCI_CSUM]  <= len_ok && (prev_xor != last_byte); // RULE7
					sci_err[SCI_NOTREADY] <= tel_ok && (rx_buf[1] == CMD_START_CODE) && !drive_ready; // RULE10
					tx_last <= RESP_HDR_LEN;
					if (tel_ok && (rx_buf[0] == own_addr || rx_buf[0] == ADDR_GLOBAL)) begin
						cmd_valid <= 1'b1;
						clr_dev   <= (rx_buf[1] == CMD_RESET_CODE); // RULE12
						state     <= TCS_CORE;
					end else if ((rx_cnt >= 4'h2) && (rx_buf[0] == own_addr)) begin
						state <= TCS_TX;
					end else begin
						state <= TCS_RX;
					end
				end
				TCS_CORE: begin
					if (core_done) begin
						sci_err[SCI_PARAM]  <= core_param_bad; // RULE6
						sci_err[SCI_MOTION] <= core_motion_bad; // RULE8
						sci_err[SCI_CMD]    <= core_unknown; // RULE11
						sci_err[SCI_DIR]    <= (core_dir_cw && !allow_cw) || (core_dir_ccw && !allow_ccw); // RULE11
						tx_last <= RESP_HDR_LEN + core_resp_len;
						state   <= reply ? TCS_TX : TCS_RX;
					end
				end
				TCS_TX: begin
					if (tx_fire && tx_idx == tx_last) begin
						state <= TCS_RX;
					end
				end
			endcase
		end
	end

	// Response byte order: address, command echo, error word high then low, parameters, checksum
	always_comb begin
		if (tx_idx == tx_last) begin
			sel_byte = tx_csum; // RULE2
		end else if (tx_idx == 4'h0) begin
			sel_byte = own_addr; // RULE24
		end else if (tx_idx == 4'h1) begin
			sel_byte = rx_buf[1]; // RULE24
		end else if (tx_idx == 4'h2) begin
			sel_byte = sci_word[15:8]; // RULE22 RULE4
		end else if (tx_idx == 4'h3) begin
			sel_byte = sci_word[7:0]; // RULE4
		end else begin
			sel_byte = resp_byte;
		end
	end

	// Transmit: one idle cycle between bytes, far below the character time
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_idx   <= 4'h0;
			tx_csum  <= 8'h00;
		end else if (state != TCS_TX) begin
			tx_valid <= 1'b0;
			tx_idx   <= 4'h0;
			tx_csum  <= 8'h00;
		end else if (!tx_valid) begin
			tx_valid <= 1'b1;
			tx_data  <= sel_byte;
			tx_csum  <= tx_csum ^ sel_byte; // RULE1
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
			tx_idx   <= tx_idx + 4'h1;
		end
	end

	// Device errors: a fault arriving with the reset command survives it
	always_comb begin
		fault_vec = 16'h0000;
		fault_vec[DEV_UNDERV]  = fault_undervolt; // RULE13
		fault_vec[DEV_POSWIN]  = fault_poswin; // RULE14
		fault_vec[DEV_TEMP]    = fault_overtemp; // RULE15
		fault_vec[DEV_BLK_CCW] = fault_block_ccw; // RULE16
		fault_vec[DEV_BLK_CW]  = fault_block_cw; // RULE17
		fault_vec[DEV_LIM_CCW] = fault_limit_ccw; // RULE18
		fault_vec[DEV_LIM_CW]  = fault_limit_cw; // RULE19
		fault_vec[DEV_MEM]     = fault_memory; // RULE20
		fault_vec[DEV_POSREC]  = fault_posrec; // RULE20
		fault_vec[DEV_TIMEOUT] = fault_comm_timeout; // RULE21
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dev_err <= 16'h0000;
		end else begin
			dev_err <= (clr_dev ? 16'h0000 : dev_err) | fault_vec; // RULE12
		end
	end

	// AXI4-Lite slave
	logic        aw_got;
	logic        w_got;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_got       <= 1'b0;
			w_got        <= 1'b0;
			aw_addr      <= 4'h0;
			w_data       <= 32'h0;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			own_addr     <= ADDR_DEFAULT;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got  <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_got && w_got) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == REG_OWN_ADDR) ? RESP_OKAY : RESP_SLVERR;
				if (aw_addr == REG_OWN_ADDR && w_strb[0]) begin
					own_addr <= w_data[7:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				REG_OWN_ADDR: s_axi_rdata <= {24'h0, own_addr};
				REG_DEV_ERR:  s_axi_rdata <= {16'h0, dev_err};
				REG_SCI_ERR:  s_axi_rdata <= {16'h0, sci_word};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	a_csum_flag: assert property (@(posedge clk) disable iff (reset) // RULE3
		(state == TCS_EVAL && len_ok && prev_xor != last_byte) |=> sci_err[SCI_CSUM])
		else $error("checksum mismatch not flagged");
	a_count_flag: assert property (@(posedge clk) disable iff (reset) // RULE7
		(state == TCS_EVAL && !len_ok) |=> sci_err[SCI_COUNT])
		else $error("bad telegram length not flagged");
	a_tx_checksum: assert property (@(posedge clk) disable iff (reset) // RULE2
		(tx_fire && tx_idx == tx_last) |-> (tx_data == $past(tx_csum, 2)))
		else $error("sent checksum wrong");
	a_tx_address: assert property (@(posedge clk) disable iff (reset) // RULE24
		(tx_fire && tx_idx == 4'h0) |-> (tx_data == own_addr))
		else $error("response does not open with own address");
	a_sci_devbit: assert property (@(posedge clk) disable iff (reset) // RULE9
		(tx_fire && tx_idx == 4'h3 && tx_idx != tx_last) |-> (tx_data[SCI_DEVERR] == (|$past(dev_err))))
		else $error("device error summary bit wrong");
	a_sci_reserved: assert property (@(posedge clk) disable iff (reset) // RULE22
		(tx_fire && tx_idx == 4'h2) |-> (tx_data[7:2] == 6'h00))
		else $error("reserved transfer error bits set");
	a_gap_hold: assert property (@(posedge clk) disable iff (reset) // RULE23
		(state == TCS_RX && rx_valid) |=> (state == TCS_RX) [*2])
		else $error("telegram closed before idle gap");
	a_dev_latch: assert property (@(posedge clk) disable iff (reset) // RULE12
		(|($past(dev_err) & ~dev_err)) |-> $past(clr_dev))
		else $error("device error dropped without reset command");
	a_temp_stop: assert property (@(posedge clk) disable iff (reset) // RULE15
		$rose(fault_overtemp) |=> drive_stop)
		else $error("overtemperature did not stop drive");
	a_block_ccw: assert property (@(posedge clk) disable iff (reset) // RULE16
		fault_block_ccw |=> (!allow_ccw && drive_stop))
		else $error("ccw blocking still allows ccw");
	a_limit_cw: assert property (@(posedge clk) disable iff (reset) // RULE19
		fault_limit_cw ##1 (!dev_err[DEV_BLK_CCW] && !dev_err[DEV_LIM_CCW]) |-> (allow_ccw && !allow_cw && drive_stop))
		else $error("cw limit direction lock wrong");

	c_response: cover property (@(posedge clk) disable iff (reset) tx_fire && tx_idx == tx_last);
	c_csum_err: cover property (@(posedge clk) disable iff (reset) state == TCS_TX && sci_err[SCI_CSUM]);
	c_reset_clr: cover property (@(posedge clk) disable iff (reset) clr_dev && (|dev_err));
endmodule : tcs_check
`default_nettype wire

/* File: tcs_link_master.sv */
`timescale 1ns/1ps
`default_nettype none
module tcs_link_master (
	input  wire logic       clk,
	input  wire logic       slow,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_fault,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] got[$];

	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		rx_fault = 1'b0;
		tx_ready = 1'b0;
	end

	// Mode 0 appends a good checksum, 1 a corrupted one, 2 none at all
	task automatic send(input logic [7:0] b[$], input int mode, input int fi);
		logic [7:0] x;
		logic [7:0] v;
		x = 8'h00;
		foreach (b[i]) x ^= b[i];
		if (mode != 2) b.push_back(mode == 1 ? ~x : x);
		foreach (b[i]) begin
			v = b[i];
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data  <= v;
			rx_fault <= (i == fi);
			@(posedge clk);
			rx_valid <= 1'b0;
			// Released line must not keep showing the last byte
			rx_data  <= ~v;
			rx_fault <= 1'b0;
		end
	endtask : send

	// A slow master accepts only every other cycle
	always @(posedge clk) begin
		if (tx_valid && tx_ready) got.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule : tcs_link_master
`default_nettype wire

/* File: telegram_check_and_error_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module telegram_check_and_error_status_tb;
	import tcs_pkg::*;
	localparam int GAP   = 20;
	localparam int LIMIT = 20000;
	logic        clk, reset, slow, rx_valid, rx_fault, tx_valid, tx_ready, cmd_valid, core_done;
	logic        core_param_bad, core_motion_bad, core_unknown, core_dir_cw, core_dir_ccw, drive_ready;
	logic        drive_stop, allow_cw, allow_ccw, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  rx_data, tx_data, cmd_code, cmd_param_byte, resp_byte;
	logic [7:0]  own = 8'hfe;
	logic [3:0]  cmd_len, core_resp_len, resp_idx, awaddr, araddr;
	logic [1:0]  bresp, rresp;
	logic [31:0] wdata, rdata;
	logic [9:0]  flt;
	int          errors = 0;
	int          checks_done = 0;
	int          cyc = 0;

	assign resp_byte = 8'ha0 ^ {4'h0, resp_idx};

	tcs_check #(.GAP_CYC(GAP)) i_tcs_check (
		.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data), .rx_fault(rx_fault),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_param_sel(3'h0), .cmd_param_byte(cmd_param_byte),
		.core_done(core_done), .core_param_bad(core_param_bad), .core_motion_bad(core_motion_bad),
		.core_unknown(core_unknown), .core_dir_cw(core_dir_cw), .core_dir_ccw(core_dir_ccw),
		.core_resp_len(core_resp_len), .resp_idx(resp_idx), .resp_byte(resp_byte), .drive_ready(drive_ready),
		.fault_undervolt(flt[0]), .fault_poswin(flt[1]), .fault_overtemp(flt[2]), .fault_block_ccw(flt[3]),
		.fault_block_cw(flt[4]), .fault_limit_ccw(flt[5]), .fault_limit_cw(flt[6]), .fault_memory(flt[7]),
		.fault_posrec(flt[8]), .fault_comm_timeout(flt[9]), .drive_stop(drive_stop), .allow_cw(allow_cw),
		.allow_ccw(allow_ccw), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	tcs_link_master i_tcs_link_master (
		.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data), .rx_fault(rx_fault),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Checks made %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("write response", bresp, er);
		@(posedge clk);
	endtask : axi_write

	task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("read data", rdata, ed);
		chk("read response", rresp, er);
		@(posedge clk);
	endtask : axi_read

	// Sends one telegram, serves the core if it was clean and checks the whole reply
	task automatic xfer(input logic [7:0] b[$], input int mode, input int fi, input bit clean,
		input logic [15:0] sci, input int np);
		logic [7:0] exp[$];
		logic [7:0] x;
		bit         seen;
		seen = 1'b0;
		i_tcs_link_master.got.delete();
		i_tcs_link_master.send(b, mode, fi);
		for (int i = 0; i < GAP + 20 && !seen; i++) begin
			@(posedge clk);
			seen = cmd_valid;
		end
		chk("command strobe", seen, clean);
		if (clean) begin
			chk("command code", cmd_code, b[1]);
			chk("command length", cmd_len, b.size() + 1);
			if (b.size() > 2) chk("first parameter", cmd_param_byte, b[2]);
			core_resp_len <= np[3:0];
			core_done     <= 1'b1;
			@(posedge clk);
			core_done <= 1'b0;
		end
		exp = '{own, b[1], sci[15:8], sci[7:0]};
		for (int i = 0; i < np; i++) exp.push_back(8'ha0 ^ i[7:0]);
		x = 8'h00;
		foreach (exp[i]) x ^= exp[i];
		exp.push_back(x);
		for (int i = 0; i < 200 && i_tcs_link_master.got.size() < exp.size(); i++) @(posedge clk);
		chk("reply length", i_tcs_link_master.got.size(), exp.size());
		foreach (exp[i]) chk("reply byte", i_tcs_link_master.got[i], exp[i]);
		@(posedge clk);
	endtask : xfer

	task automatic t_errors();
		logic [7:0] q[$];
		q = '{8'hfe, 8'h11};
		repeat (12) q.push_back(8'h5a);
		xfer('{8'hfe, 8'h11}, 0, -1, 1, 16'h0000, 2);
		xfer('{8'hfe, 8'h11}, 0, 1, 0, 16'h0001, 0);
		xfer('{8'hfe, 8'h11}, 1, -1, 0, 16'h0004, 0);
		xfer('{8'hfe, 8'h11}, 2, -1, 0, 16'h0010, 0);
		xfer(q, 0, -1, 0, 16'h0010, 0);
		$display("t_errors done");
	endtask : t_errors

	// Global telegrams act but are never answered, and must not be acted on twice
	task automatic t_global();
		logic [7:0] q[$];
		bit         seen;
		int         n;
		q    = '{ADDR_GLOBAL, 8'h32};
		seen = 1'b0;
		n    = 0;
		i_tcs_link_master.got.delete();
		i_tcs_link_master.send(q, 0, -1);
		for (int i = 0; i < GAP + 20 && !seen; i++) begin
			@(posedge clk);
			seen = cmd_valid;
		end
		chk("global strobe", seen, 1'b1);
		chk("global code", cmd_code, 8'h32);
		core_resp_len <= 4'h0;
		core_done     <= 1'b1;
		@(posedge clk);
		core_done <= 1'b0;
		for (int i = 0; i < GAP + 20; i++) begin
			@(posedge clk);
			if (cmd_valid) n++;
		end
		chk("global strobe repeat", n, 0);
		chk("global reply length", i_tcs_link_master.got.size(), 0);
		$display("t_global done");
	endtask : t_global

	task automatic t_core();
		drive_ready     <= 1'b0;
		core_param_bad  <= 1'b1;
		core_motion_bad <= 1'b1;
		core_unknown    <= 1'b1;
		slow            <= 1'b1;
		xfer('{8'hfe, CMD_START_CODE, 8'h55}, 0, -1, 1, 16'h028a, 3);
		drive_ready     <= 1'b1;
		core_param_bad  <= 1'b0;
		core_motion_bad <= 1'b0;
		core_unknown    <= 1'b0;
		slow            <= 1'b0;
		$display("t_core done");
	endtask : t_core

	task automatic t_faults();
		int          pos[10] = '{1, 2, 3, 4, 5, 8, 9, 12, 14, 15};
		logic [15:0] e;
		e = 16'h0000;
		for (int i = 0; i < 10; i++) begin
			flt <= 10'h001 << i;
			@(posedge clk);
			flt <= 10'h000;
			e[pos[i]] = 1'b1;
			axi_read(REG_DEV_ERR, {16'h0000, e}, RESP_OKAY);
			chk("drive stop", drive_stop, |(e & 16'h0338));
			chk("cw allowed", allow_cw, !(e[5] | e[9]));
			chk("ccw allowed", allow_ccw, !(e[4] | e[8]));
		end
		// Both blockings latched, so a ccw request is a wrong direction
		core_dir_ccw <= 1'b1;
		xfer('{8'hfe, 8'h11}, 0, -1, 1, 16'h0140, 0);
		axi_read(REG_SCI_ERR, 32'h0000_0140, RESP_OKAY);
		core_dir_ccw <= 1'b0;
		xfer('{8'hfe, CMD_RESET_CODE}, 0, -1, 1, 16'h0000, 0);
		axi_read(REG_DEV_ERR, 32'h0000_0000, RESP_OKAY);
		chk("stop after clear", drive_stop, 1'b0);
		// Lone cw limit: drive stops, cw locked, ccw still free
		flt <= 10'h040;
		@(posedge clk);
		flt <= 10'h000;
		@(posedge clk);
		chk("limit stop", drive_stop, 1'b1);
		chk("limit cw allowed", allow_cw, 1'b0);
		chk("limit ccw allowed", allow_ccw, 1'b1);
		xfer('{8'hfe, CMD_RESET_CODE}, 0, -1, 1, 16'h0000, 0);
		$display("t_faults done");
	endtask : t_faults

	task automatic t_axi();
		axi_read(REG_OWN_ADDR, 32'h0000_00fe, RESP_OKAY);
		axi_write(REG_OWN_ADDR, 32'h0000_0023, RESP_OKAY);
		axi_read(REG_OWN_ADDR, 32'h0000_0023, RESP_OKAY);
		axi_write(REG_DEV_ERR, 32'h0000_ffff, RESP_SLVERR);
		axi_read(REG_DEV_ERR, 32'h0000_0000, RESP_OKAY);
		axi_write(4'hc, 32'h0000_0001, RESP_SLVERR);
		axi_read(4'hc, 32'h0000_0000, RESP_SLVERR);
		own = 8'h23;
		xfer('{8'h23, 8'h11}, 0, -1, 1, 16'h0000, 1);
		$display("t_axi done");
	endtask : t_axi

	initial begin
		reset = 1'b1;
		drive_ready = 1'b1;
		flt = 10'h000;
		{slow, core_done, core_param_bad, core_motion_bad, core_unknown, core_dir_cw, core_dir_ccw} = '0;
		{awvalid, wvalid, bready, arvalid, rready, core_resp_len, awaddr, araddr, wdata} = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_errors();
		t_global();
		t_core();
		t_faults();
		t_axi();
		complete_run();
	end
endmodule : telegram_check_and_error_status_tb
`default_nettype wire
